// ### hdl/lei_link_inject.sv
`timescale 1ns/1ps
`default_nettype none
module lei_link_inject #(
  parameter int LANES = 4,
  parameter int SEQ_W = 12,
  parameter int HDR_W = 8,
  parameter int DATA_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // static test inputs
  input wire logic [1:0] rx_check_sel,
  input wire logic replay_force,
  input wire logic [1:0] ack_subst_sel,
  input wire logic ecrc_inject,
  input wire logic lcrc_inject,
  input wire logic [1:0] tx_crc_sel,
  input wire logic [4:0] credit_code,
  // received dllp from the link
  input wire logic rx_dllp_valid,
  input wire logic [1:0] rx_dllp_type,
  output logic rx_dllp_force_err,
  // retry buffer
  output logic replay_start,
  // ack/nak to be transmitted
  input wire logic ack_in_valid,
  input wire logic ack_in_is_nak,
  input wire logic [SEQ_W-1:0] ack_in_seq,
  output logic ack_out_valid,
  output logic ack_out_is_nak,
  output logic [SEQ_W-1:0] ack_out_seq,
  // transmitted tlp crc corruption
  output logic tlp_ecrc_corrupt,
  output logic tlp_lcrc_corrupt,
  // transmitted dllp
  input wire logic tx_dllp_valid,
  input wire logic [1:0] tx_dllp_type,
  output logic tx_dllp_out_valid,
  output logic tx_dllp_crc_corrupt,
  // flow-control update
  input wire logic fc_in_valid,
  input wire logic fc_in_drain,
  input wire logic [1:0] fc_in_class,
  input wire logic [HDR_W-1:0] fc_in_hdr,
  input wire logic [DATA_W-1:0] fc_in_data,
  output logic fc_out_valid,
  output logic [1:0] fc_out_class,
  output logic [HDR_W-1:0] fc_out_hdr,
  output logic [DATA_W-1:0] fc_out_data
);
  import lei_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic rx_armed;
    logic [1:0] rx_sel_q;
    logic rx_force;
    logic replay_q;
    logic replay_go;
    logic ack_v;
    logic ack_nak;
    logic [SEQ_W-1:0] ack_seq;
    logic ecrc;
    logic lcrc;
    logic txd_v;
    logic txd_bad;
    logic fc_v;
    logic [1:0] fc_cls;
    logic [HDR_W-1:0] fc_hdr;
    logic [DATA_W-1:0] fc_data;
  } lei_state_t;

  lei_state_t st_reg;
  lei_state_t st_next;

  localparam bit NARROW_OK = (LANES != LEI_RESERVED_LANES);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // adds or removes one unit, wrapping like the credit counters
  function automatic logic [15:0] lei_adjust(input logic [15:0] v, input logic inc,
                                             input logic dec);
    lei_adjust = inc ? v + 16'h0001 : (dec ? v - 16'h0001 : v);
  endfunction : lei_adjust

  // does a received dllp type match the receive-check code
  function automatic logic lei_rx_match(input logic [1:0] sel, input logic [1:0] typ);
    case (sel)
      LEI_RXCHK_ACKNAK: lei_rx_match = (typ == LEI_DLLP_ACK) || (typ == LEI_DLLP_NAK);
      LEI_RXCHK_PM: lei_rx_match = (typ == LEI_DLLP_PM);
      LEI_RXCHK_FC: lei_rx_match = (typ == LEI_DLLP_FC);
      default: lei_rx_match = 1'b0;
    endcase
  endfunction : lei_rx_match

  // does a transmitted dllp type match the tx crc code
  function automatic logic lei_tx_match(input logic [1:0] sel, input logic [1:0] typ);
    case (sel)
      LEI_TXCRC_PM: lei_tx_match = (typ == LEI_DLLP_PM);
      LEI_TXCRC_FC: lei_tx_match = (typ == LEI_DLLP_FC);
      LEI_TXCRC_ACK: lei_tx_match = (typ == LEI_DLLP_ACK);
      default: lei_tx_match = 1'b0;
    endcase
  endfunction : lei_tx_match

  // ****************************************************************
  // field masking for the eight-lane variant
  // ****************************************************************
  logic [1:0] rx_sel_eff;
  logic replay_eff;
  logic [1:0] sub_eff;
  logic lcrc_eff;
  logic [1:0] txcrc_eff;
  logic [4:0] ufc_eff;

  // reserved fields are zeroed so they act as normal mode
  assign rx_sel_eff = NARROW_OK ? rx_check_sel : LEI_RXCHK_OFF;
  assign replay_eff = NARROW_OK && replay_force;
  assign sub_eff = NARROW_OK ? ack_subst_sel : LEI_SUB_OFF;
  assign lcrc_eff = NARROW_OK && lcrc_inject;
  assign txcrc_eff = NARROW_OK ? tx_crc_sel : LEI_TXCRC_OFF;
  assign ufc_eff = credit_code;

  // ****************************************************************
  // credit decode
  // ****************************************************************
  logic ufc_active;
  logic [1:0] ufc_cls;
  logic ufc_hi;
  logic ufc_hd;
  logic ufc_di;
  logic ufc_dd;

  lei_credit_decode u_decode (
    .code(ufc_eff),
    .active(ufc_active),
    .cls(ufc_cls),
    .hdr_inc(ufc_hi),
    .hdr_dec(ufc_hd),
    .data_inc(ufc_di),
    .data_dec(ufc_dd)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  logic rx_hit;
  logic rx_arm;
  logic fc_hit;

  always_comb begin
    st_next = st_reg;
    // arm on a new nonzero check code; the next matching dllp consumes it
    rx_arm = (rx_sel_eff != st_reg.rx_sel_q) && (rx_sel_eff != LEI_RXCHK_OFF);
    rx_hit = rx_dllp_valid && st_reg.rx_armed && lei_rx_match(rx_sel_eff, rx_dllp_type);
    st_next.rx_sel_q = rx_sel_eff;
    st_next.rx_force = rx_hit;
    // a re-arm in the same cycle as a hit wins over the clear
    st_next.rx_armed = rx_arm ? 1'b1 : (rx_hit ? 1'b0 : st_reg.rx_armed);
    // one replay per assertion of the force bit
    st_next.replay_q = replay_eff;
    st_next.replay_go = replay_eff && !st_reg.replay_q;
    // ack to nak substitution
    st_next.ack_v = ack_in_valid;
    st_next.ack_nak = ack_in_is_nak;
    st_next.ack_seq = ack_in_seq;
    if (ack_in_valid && !ack_in_is_nak && sub_eff != LEI_SUB_OFF) begin
      st_next.ack_nak = 1'b1;
      case (sub_eff)
        LEI_SUB_INC: st_next.ack_seq = ack_in_seq + SEQ_W'(1);
        LEI_SUB_DEC: st_next.ack_seq = ack_in_seq - SEQ_W'(1);
        default: st_next.ack_seq = ack_in_seq;
      endcase
    end
    // tlp crc corruption levels
    st_next.ecrc = ecrc_inject;
    st_next.lcrc = lcrc_eff;
    // dllp crc corruption on transmit
    st_next.txd_v = tx_dllp_valid;
    st_next.txd_bad = tx_dllp_valid && lei_tx_match(txcrc_eff, tx_dllp_type);
    // flow-control update, corrupted when a drained tlp triggers it
    fc_hit = fc_in_drain && ufc_active && (fc_in_class == ufc_cls);
    st_next.fc_v = fc_in_valid;
    st_next.fc_cls = fc_in_class;
    st_next.fc_hdr = fc_in_hdr;
    st_next.fc_data = fc_in_data;
    if (fc_in_valid && fc_hit) begin
      st_next.fc_hdr = HDR_W'(lei_adjust(16'(fc_in_hdr), ufc_hi, ufc_hd));
      st_next.fc_data = DATA_W'(lei_adjust(16'(fc_in_data), ufc_di, ufc_dd));
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rx_dllp_force_err = st_reg.rx_force;
  assign replay_start = st_reg.replay_go;
  assign ack_out_valid = st_reg.ack_v;
  assign ack_out_is_nak = st_reg.ack_nak;
  assign ack_out_seq = st_reg.ack_seq;
  assign tlp_ecrc_corrupt = st_reg.ecrc;
  assign tlp_lcrc_corrupt = st_reg.lcrc;
  assign tx_dllp_out_valid = st_reg.txd_v;
  assign tx_dllp_crc_corrupt = st_reg.txd_bad;
  assign fc_out_valid = st_reg.fc_v;
  assign fc_out_class = st_reg.fc_cls;
  assign fc_out_hdr = st_reg.fc_hdr;
  assign fc_out_data = st_reg.fc_data;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_ack_in;
    ack_in_valid && !ack_in_is_nak;
  endsequence

  // forced-error flag is a single-cycle pulse once the check is consumed
  sequence s_rx_pulse;
    rx_dllp_force_err ##1 !rx_dllp_force_err;
  endsequence

  property p_rx_force;
    @(posedge clk) disable iff (sys_rst)
      (rx_hit && !rx_arm) |=> s_rx_pulse;
  endproperty
  a_rx_force: assert property (p_rx_force) else $error("rx force pulse missing");

  property p_rx_once;
    @(posedge clk) disable iff (sys_rst)
      (rx_hit && !rx_arm) |=> !st_reg.rx_armed;
  endproperty
  a_rx_once: assert property (p_rx_once) else $error("rx check not consumed");

  property p_replay;
    @(posedge clk) disable iff (sys_rst)
      (replay_eff && !st_reg.replay_q) |=> replay_start ##1 !replay_start;
  endproperty
  a_replay: assert property (p_replay) else $error("replay pulse wrong");

  property p_ack_inc;
    @(posedge clk) disable iff (sys_rst)
      (s_ack_in and sub_eff == LEI_SUB_INC) |=>
        ack_out_is_nak && ack_out_seq == $past(ack_in_seq) + SEQ_W'(1);
  endproperty
  a_ack_inc: assert property (p_ack_inc) else $error("nak seq not incremented");

  property p_ack_pass;
    @(posedge clk) disable iff (sys_rst)
      (s_ack_in and sub_eff == LEI_SUB_OFF) |=>
        !ack_out_is_nak && ack_out_seq == $past(ack_in_seq);
  endproperty
  a_ack_pass: assert property (p_ack_pass) else $error("ack altered in normal mode");

  property p_ecrc;
    @(posedge clk) disable iff (sys_rst)
      ##1 tlp_ecrc_corrupt == $past(ecrc_inject);
  endproperty
  a_ecrc: assert property (p_ecrc) else $error("ecrc corrupt wrong");

  property p_lcrc;
    @(posedge clk) disable iff (sys_rst)
      ##1 tlp_lcrc_corrupt == ($past(lcrc_inject) && NARROW_OK);
  endproperty
  a_lcrc: assert property (p_lcrc) else $error("lcrc corrupt wrong");

  property p_txcrc;
    @(posedge clk) disable iff (sys_rst)
      (tx_dllp_valid && tx_dllp_type == LEI_DLLP_ACK && txcrc_eff == LEI_TXCRC_ACK)
        |=> tx_dllp_out_valid && tx_dllp_crc_corrupt;
  endproperty
  a_txcrc: assert property (p_txcrc) else $error("ack dllp not corrupted");

  property p_cpl_both;
    @(posedge clk) disable iff (sys_rst)
      (fc_in_valid && fc_in_drain && fc_in_class == LEI_CLS_COMPLETION &&
       ufc_eff == LEI_COMPLETION_CREDIT_UPDATE_BOTH_DEC) |=>
        fc_out_hdr == $past(fc_in_hdr) - HDR_W'(1) &&
        fc_out_data == $past(fc_in_data) - DATA_W'(1);
  endproperty
  a_cpl_both: assert property (p_cpl_both) else $error("cpl both credits wrong");

  property p_cpl_data;
    @(posedge clk) disable iff (sys_rst)
      (fc_in_valid && fc_in_drain && fc_in_class == LEI_CLS_COMPLETION &&
       ufc_eff == LEI_COMPLETION_CREDIT_UPDATE_DATA_DEC) |=>
        fc_out_hdr == $past(fc_in_hdr) && fc_out_data == $past(fc_in_data) - DATA_W'(1);
  endproperty
  a_cpl_data: assert property (p_cpl_data) else $error("cpl data credit wrong");

  property p_fc_nodrain;
    @(posedge clk) disable iff (sys_rst)
      (fc_in_valid && (!fc_in_drain || ufc_eff == LEI_UFC_OFF)) |=>
        fc_out_hdr == $past(fc_in_hdr) && fc_out_data == $past(fc_in_data);
  endproperty
  a_fc_nodrain: assert property (p_fc_nodrain) else $error("credits altered");

endmodule : lei_link_inject
`default_nettype wire

// ### hdl/lei_pkg.sv
// ****************************************************************
// constants for the link-layer error injection slice
// ****************************************************************
package lei_pkg;

  // receive-check field codes
  localparam logic [1:0] LEI_RXCHK_OFF = 2'h0;
  localparam logic [1:0] LEI_RXCHK_ACKNAK = 2'h1;
  localparam logic [1:0] LEI_RXCHK_PM = 2'h2;
  localparam logic [1:0] LEI_RXCHK_FC = 2'h3;

  // acknowledge-substitution field codes
  localparam logic [1:0] LEI_SUB_OFF = 2'h0;
  localparam logic [1:0] LEI_SUB_SAME = 2'h1;
  localparam logic [1:0] LEI_SUB_INC = 2'h2;
  localparam logic [1:0] LEI_SUB_DEC = 2'h3;

  // transmit control-packet crc field codes
  localparam logic [1:0] LEI_TXCRC_OFF = 2'h0;
  localparam logic [1:0] LEI_TXCRC_PM = 2'h1;
  localparam logic [1:0] LEI_TXCRC_FC = 2'h2;
  localparam logic [1:0] LEI_TXCRC_ACK = 2'h3;

  // control-packet type on the core's dllp ports
  localparam logic [1:0] LEI_DLLP_ACK = 2'h0;
  localparam logic [1:0] LEI_DLLP_NAK = 2'h1;
  localparam logic [1:0] LEI_DLLP_PM = 2'h2;
  localparam logic [1:0] LEI_DLLP_FC = 2'h3;

  // credit classes of a flow-control update
  localparam logic [1:0] LEI_CLS_POSTED = 2'h0;
  localparam logic [1:0] LEI_CLS_NONPOSTED = 2'h1;
  localparam logic [1:0] LEI_CLS_COMPLETION = 2'h2;

  // credit-corruption code ranges
  localparam logic [4:0] LEI_UFC_OFF = 5'h00;
  localparam logic [4:0] LEI_UFC_INC_LAST = 5'h09;
  localparam logic [4:0] LEI_UFC_DEC_FIRST = 5'h0A;
  localparam logic [4:0] LEI_UFC_DEC_LAST = 5'h12;
  localparam logic [4:0] LEI_COMPLETION_CREDIT_UPDATE_DATA_DEC = 5'h11;
  localparam logic [4:0] LEI_COMPLETION_CREDIT_UPDATE_BOTH_DEC = 5'h12;

  // lane count of the variant whose link-layer test bits are reserved
  localparam int LEI_RESERVED_LANES = 8;

  // reset values
  localparam logic [1:0] LEI_RST_SEL = 2'h0;

endpackage : lei_pkg

// ### hdl/lei_credit_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// credit-corruption code decoder
// ****************************************************************
module lei_credit_decode (
  // code in
  input wire logic [4:0] code,
  // decoded adjustment
  output logic active,
  output logic [1:0] cls,
  output logic hdr_inc,
  output logic hdr_dec,
  output logic data_inc,
  output logic data_dec
);
  import lei_pkg::*;

  logic [4:0] idx;
  logic dec;

  // codes 1..9 add a credit, 10..18 remove one; three per class
  always_comb begin
    active = 1'b0;
    dec = 1'b0;
    idx = 5'h00;
    if (code != LEI_UFC_OFF && code <= LEI_UFC_INC_LAST) begin
      active = 1'b1;
      idx = code - 5'h01;
    end else if (code >= LEI_UFC_DEC_FIRST && code <= LEI_UFC_DEC_LAST) begin
      active = 1'b1;
      dec = 1'b1;
      idx = code - LEI_UFC_DEC_FIRST;
    end
    cls = 2'(idx / 5'h03);
    hdr_inc = active && !dec && (idx % 5'h03) != 5'h01;
    hdr_dec = active && dec && (idx % 5'h03) != 5'h01;
    data_inc = active && !dec && (idx % 5'h03) != 5'h00;
    data_dec = active && dec && (idx % 5'h03) != 5'h00;
  end

endmodule : lei_credit_decode
`default_nettype wire

// ### bench/lei_test_src.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// application-side source of the static test fields
// ****************************************************************
module lei_test_src (
  // static test fields
  output logic [1:0] rx_check_sel,
  output logic replay_force,
  output logic [1:0] ack_subst_sel,
  output logic ecrc_inject,
  output logic lcrc_inject,
  output logic [1:0] tx_crc_sel,
  output logic [4:0] credit_code
);
  // unused fields sit tied at zero from time zero
  initial begin
    {rx_check_sel, replay_force, ack_subst_sel, ecrc_inject} = '0;
    {lcrc_inject, tx_crc_sel, credit_code} = '0;
  end
  // called just after a clock edge so the fields settle before the next one
  task set_fields(input logic [1:0] rxc, input logic rp, input logic [1:0] sub,
                  input logic ec, input logic lc, input logic [1:0] txc,
                  input logic [4:0] cc);
    rx_check_sel = rxc;
    replay_force = rp;
    ack_subst_sel = sub;
    ecrc_inject = ec;
    lcrc_inject = lc;
    tx_crc_sel = txc;
    credit_code = cc;
  endtask : set_fields
endmodule : lei_test_src
`default_nettype wire

// ### bench/tb_lei_link_inject.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// self-checking bench for the link-layer error injection slice
// ****************************************************************
module tb_lei_link_inject;
  import lei_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic [1:0] rx_check_sel, ack_subst_sel, tx_crc_sel;
  wire logic replay_force, ecrc_inject, lcrc_inject;
  wire logic [4:0] credit_code;
  logic rx_dllp_valid, ack_in_valid, ack_in_is_nak, tx_dllp_valid, fc_in_valid, fc_in_drain;
  logic [1:0] rx_dllp_type, tx_dllp_type, fc_in_class;
  logic [11:0] ack_in_seq, fc_in_data, es, ed;
  logic [7:0] fc_in_hdr, eh;
  logic rx_fe, rp_st, ao_v, ao_n, ecc, lcc, tx_ov, tx_cc, fo_v, exp_b;
  logic rx_fe_8, rp_st_8, ao_v_8, ao_n_8, ecc_8, lcc_8, tx_ov_8, tx_cc_8, fo_v_8;
  logic [11:0] ao_s, fo_d, ao_s_8, fo_d_8;
  logic [1:0] fo_c, fo_c_8;
  logic [7:0] fo_h, fo_h_8;
  int err_total = 0;
  int tests_run = 0;
  int armed, idx;

  // clock, 4 ns period
  always #2 clk = ~clk;

  // ****************************************************************
  // partner and the two variants
  // ****************************************************************
  lei_test_src src (.rx_check_sel, .replay_force, .ack_subst_sel, .ecrc_inject,
    .lcrc_inject, .tx_crc_sel, .credit_code);
  lei_link_inject dut (.clk, .sys_rst, .rx_check_sel, .replay_force, .ack_subst_sel,
    .ecrc_inject, .lcrc_inject, .tx_crc_sel, .credit_code, .rx_dllp_valid, .rx_dllp_type,
    .rx_dllp_force_err(rx_fe), .replay_start(rp_st), .ack_in_valid, .ack_in_is_nak,
    .ack_in_seq, .ack_out_valid(ao_v), .ack_out_is_nak(ao_n), .ack_out_seq(ao_s),
    .tlp_ecrc_corrupt(ecc), .tlp_lcrc_corrupt(lcc), .tx_dllp_valid, .tx_dllp_type,
    .tx_dllp_out_valid(tx_ov), .tx_dllp_crc_corrupt(tx_cc), .fc_in_valid, .fc_in_drain,
    .fc_in_class, .fc_in_hdr, .fc_in_data, .fc_out_valid(fo_v), .fc_out_class(fo_c),
    .fc_out_hdr(fo_h), .fc_out_data(fo_d));
  lei_link_inject #(.LANES(LEI_RESERVED_LANES)) dut_x8 (.clk, .sys_rst, .rx_check_sel,
    .replay_force, .ack_subst_sel, .ecrc_inject, .lcrc_inject, .tx_crc_sel, .credit_code,
    .rx_dllp_valid, .rx_dllp_type, .rx_dllp_force_err(rx_fe_8), .replay_start(rp_st_8),
    .ack_in_valid, .ack_in_is_nak, .ack_in_seq, .ack_out_valid(ao_v_8),
    .ack_out_is_nak(ao_n_8), .ack_out_seq(ao_s_8), .tlp_ecrc_corrupt(ecc_8),
    .tlp_lcrc_corrupt(lcc_8), .tx_dllp_valid, .tx_dllp_type, .tx_dllp_out_valid(tx_ov_8),
    .tx_dllp_crc_corrupt(tx_cc_8), .fc_in_valid, .fc_in_drain, .fc_in_class, .fc_in_hdr,
    .fc_in_data, .fc_out_valid(fo_v_8), .fc_out_class(fo_c_8), .fc_out_hdr(fo_h_8),
    .fc_out_data(fo_d_8));

  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  // waits for the falling edge, then drives all strobes in one assignment
  task drop(input logic [4:0] v);
    @(negedge clk);
    {rx_dllp_valid, ack_in_valid, ack_in_is_nak, tx_dllp_valid, fc_in_valid} = v;
  endtask : drop
  // sample edge, then let registered outputs settle
  task go();
    @(posedge clk);
    #1;
  endtask : go
  task chk_b(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_b
  task chk_v(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_v
  task final_report();
    $display("checks run %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // watchdog against a hung run
  initial begin
    #200000;
    err_total++;
    final_report();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rx_dllp_valid, ack_in_valid, ack_in_is_nak, tx_dllp_valid, fc_in_valid} = '0;
    {rx_dllp_type, tx_dllp_type, fc_in_class, ack_in_seq, fc_in_drain} = '0;
    fc_in_hdr = 8'h00;
    fc_in_data = 12'hFFF;
    go();
    go();
    chk_v({rx_fe, rp_st, ao_v, ao_n, ao_s, ecc, lcc, tx_ov, tx_cc, fo_v, fo_c, fo_h, fo_d}, 64'h0);
    @(negedge clk);
    sys_rst = 1'b0;
    // ack substitution codes with sequence wrap at both ends
    for (int s = 0; s < 4; s++) begin
      drop(5'b01000);
      src.set_fields(2'h0, 1'b0, 2'(s), 1'b0, 1'b0, 2'h0, 5'h00);
      ack_in_seq = (s == 3) ? 12'h000 : 12'hFFF;
      go();
      es = ack_in_seq + ((s == 2) ? 12'h001 : 12'h000) - ((s == 3) ? 12'h001 : 12'h000);
      chk_b(ao_v, 1'b1);
      chk_b(ao_n, 1'(s != 0));
      chk_v(ao_s, es);
      chk_v({ao_v_8, ao_n_8, ao_s_8}, {2'b10, ack_in_seq});
    end
    // a nak is never altered
    drop(5'b01100);
    ack_in_seq = 12'h123;
    go();
    chk_v({ao_n, ao_s}, {1'b1, 12'h123});
    // transmit control-packet crc codes against every packet type
    for (int c = 0; c < 4; c++) begin
      for (int t = 0; t < 4; t++) begin
        drop(5'b00010);
        src.set_fields(2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 2'(c), 5'h00);
        tx_dllp_type = 2'(t);
        go();
        exp_b = (c == 1 && t == 2) || (c == 2 && t == 3) || (c == 3 && t == 0);
        chk_v({tx_ov, tx_cc}, {1'b1, exp_b});
        chk_v({tx_ov_8, tx_cc_8}, 2'b10);
      end
    end
    // transaction crc corruption levels
    drop(5'b00000);
    src.set_fields(2'h0, 1'b0, 2'h0, 1'b1, 1'b0, 2'h0, 5'h00);
    go();
    chk_v({ecc, lcc, ecc_8}, 3'b101);
    drop(5'b00000);
    src.set_fields(2'h0, 1'b0, 2'h0, 1'b0, 1'b1, 2'h0, 5'h00);
    go();
    chk_v({ecc, lcc, lcc_8}, 3'b010);
    // replay force gives one start pulse
    drop(5'b00000);
    src.set_fields(2'h0, 1'b1, 2'h0, 1'b0, 1'b0, 2'h0, 5'h00);
    go();
    chk_v({rp_st, rp_st_8}, 2'b10);
    drop(5'b00000);
    go();
    chk_b(rp_st, 1'b0);
    // receive check arms once per code change
    for (int c = 1; c < 4; c++) begin
      drop(5'b00000);
      src.set_fields(2'(c), 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 5'h00);
      go();
      armed = 1;
      for (int t = 0; t < 4; t++) begin
        drop(5'b10000);
        rx_dllp_type = 2'(t);
        go();
        exp_b = (armed == 1) && ((c == 1 && t < 2) || (c > 1 && c == t));
        if (exp_b) armed = 0;
        chk_b(rx_fe, exp_b);
        chk_b(rx_fe_8, 1'b0);
      end
      drop(5'b00000);
      src.set_fields(2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 5'h00);
      go();
    end
    // credit codes 0 to 19 against every class, at wrap boundaries
    for (int k = 0; k < 20; k++) begin
      for (int cl = 0; cl < 3; cl++) begin
        drop(5'b00001);
        src.set_fields(2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 5'(k));
        {fc_in_drain, fc_in_class} = {1'b1, 2'(cl)};
        go();
        eh = 8'h00;
        ed = 12'hFFF;
        idx = (k <= 9) ? k - 1 : k - 10;
        if (k >= 1 && k <= 18 && idx / 3 == cl) begin
          if (idx % 3 != 1) eh = (k <= 9) ? 8'h01 : 8'hFF;
          if (idx % 3 != 0) ed = (k <= 9) ? 12'h000 : 12'hFFE;
        end
        chk_v({fo_v, fo_c, fo_h, fo_d}, {1'b1, 2'(cl), eh, ed});
        chk_v({fo_v_8, fo_c_8, fo_h_8, fo_d_8}, {1'b1, 2'(cl), eh, ed});
      end
    end
    // an update not caused by a drain is left alone, even under a live completion code
    drop(5'b00001);
    src.set_fields(2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, LEI_COMPLETION_CREDIT_UPDATE_BOTH_DEC);
    {fc_in_drain, fc_in_class} = {1'b0, LEI_CLS_COMPLETION};
    go();
    chk_v({fo_h, fo_d}, {8'h00, 12'hFFF});
    // mid-run reset clears outputs; a check code present at release arms one check
    drop(5'b00000);
    src.set_fields(LEI_RXCHK_ACKNAK, 1'b0, 2'h0, 1'b0, 1'b0, 2'h0, 5'h00);
    sys_rst = 1'b1;
    go();
    chk_v({rx_fe, rp_st, ao_v, ecc, lcc, tx_ov, fo_v, fo_c, fo_h, fo_d}, 64'h0);
    drop(5'b10000);
    sys_rst = 1'b0;
    rx_dllp_type = LEI_DLLP_ACK;
    go();
    chk_b(rx_fe, 1'b0);
    go();
    chk_b(rx_fe, 1'b1);
    go();
    chk_b(rx_fe, 1'b0);
    final_report();
  end
endmodule : tb_lei_link_inject
`default_nettype wire
